// file: hw/sfrp_consts.svh
/*
  Constants of the buffer read port: sizes, reset values, register offsets
  and field positions.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef SFRP_CONSTS_SVH
`define SFRP_CONSTS_SVH

`define SFRP_ENTRIES        256
`define SFRP_PTR_W          8
`define SFRP_WORD_W         9
`define SFRP_LEVEL_W        9
`define SFRP_AE_OFFSET_RST  8'h07
`define SFRP_AF_OFFSET_RST  8'h07
`define SFRP_ADDR_W         8

`define SFRP_REG_AE_OFFSET  8'h00
`define SFRP_REG_AF_OFFSET  8'h04
`define SFRP_REG_STATUS     8'h08
`define SFRP_REG_IRQ_STATUS 8'h0c
`define SFRP_REG_IRQ_MASK   8'h10

`define SFRP_STAT_FLAGS_LSB 16
`define SFRP_IRQ_W          6
`define SFRP_IRQ_EMPTY      0
`define SFRP_IRQ_AEMPTY     1
`define SFRP_IRQ_AFULL      2
`define SFRP_IRQ_FULL       3
`define SFRP_IRQ_OVERFLOW   4
`define SFRP_IRQ_UNDERFLOW  5
`define SFRP_IRQ_MASK_RST   6'h00

`define SFRP_RESP_OKAY      2'h0
`define SFRP_RESP_SLVERR    2'h2

`endif

// file: hw/sfrp_pkg.sv
/*
  Types shared by the buffer read port modules.
  Assumes the constants header is on the include path.
*/
`include "sfrp_consts.svh"
`default_nettype none

package sfrp_pkg;

  typedef logic [`SFRP_WORD_W-1:0]  sfrp_word_t;
  typedef logic [`SFRP_PTR_W-1:0]   sfrp_ptr_t;
  typedef logic [`SFRP_LEVEL_W-1:0] sfrp_level_t;
  typedef logic [7:0]               sfrp_offset_t;
  typedef logic [`SFRP_IRQ_W-1:0]   sfrp_irq_t;

  typedef struct packed {
    logic [`SFRP_ENTRIES-1:0][`SFRP_WORD_W-1:0] mem;
    sfrp_word_t                                 rd_data;
  } sfrp_ram_st_t;

  typedef struct packed {
    logic flag_n;
    logic asserted;
  } sfrp_flag_st_t;

endpackage : sfrp_pkg

`default_nettype wire

// file: hw/sfrp_level_flag.sv
/*
  One registered active-low level flag with a one-cycle pulse when it
  asserts.
  Assumes level is the fill level that the buffer holds after this edge.
*/
`include "sfrp_consts.svh"
`default_nettype none

module sfrp_level_flag #(
  parameter bit AT_OR_ABOVE = 1'b0
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire sfrp_pkg::sfrp_level_t level,
  input  wire sfrp_pkg::sfrp_offset_t offset,
  output logic                       flag_n,
  output logic                       asserted
);

  sfrp_pkg::sfrp_flag_st_t q;
  sfrp_pkg::sfrp_flag_st_t d;
  sfrp_pkg::sfrp_level_t   limit;
  logic                    hit;

  // Full side flags trip at capacity minus offset, empty side at offset.
  always_comb begin
    limit = `SFRP_LEVEL_W'(`SFRP_ENTRIES) - {1'b0, offset};
    if (AT_OR_ABOVE) begin
      hit = (level >= limit);
    end else begin
      hit = (level <= {1'b0, offset});
    end
    d.flag_n   = ~hit;
    d.asserted = hit & q.flag_n;
  end

  // Empty side flags come out of reset low, full side flags high.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q.flag_n   <= AT_OR_ABOVE;
      q.asserted <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign flag_n   = q.flag_n;
  assign asserted = q.asserted;

endmodule : sfrp_level_flag

`default_nettype wire

// file: hw/sfrp_ram.sv
/*
  Storage array of the buffer with a registered output word.
  Assumes the caller never writes a full buffer nor reads an empty one.
*/
`include "sfrp_consts.svh"
`default_nettype none

module sfrp_ram (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 wr_en,
  input  wire sfrp_pkg::sfrp_ptr_t  wr_addr,
  input  wire sfrp_pkg::sfrp_word_t wr_data,
  input  wire logic                 rd_en,
  input  wire sfrp_pkg::sfrp_ptr_t  rd_addr,
  output sfrp_pkg::sfrp_word_t      rd_data
);

  sfrp_pkg::sfrp_ram_st_t q;
  sfrp_pkg::sfrp_ram_st_t d;

  always_comb begin
    d = q;
    if (wr_en) begin
      d.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      d.rd_data = q.mem[rd_addr];
    end
  end

  // The output word clears to zero on reset and holds except on a read.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;

endmodule : sfrp_ram

`default_nettype wire

// file: hw/sfrp_fifo_read_port.sv
/*
  Synchronous 256 x 9 buffer: write port, read port with output drive
  control, four active-low status flags, register file on AXI4-Lite and
  one level interrupt.
  Assumes one clock for both ports and inputs synchronous to it.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
//
// Contract
// - Both read enables low reads one word
// - No read while empty flag low
// - Drive enable low drives bus, else released
// - Empty flag low exactly when no words
// - Almost-empty low within programmed offset
// - Almost-empty offset resets to seven
// - Almost-full low within offset of capacity
// - Almost-full offset resets to seven
// - Full low when full, writes ignored
// - Full returns high when no longer full
// - Reset clears pointers, sets flag levels
// - Write enable stores word each edge
`include "sfrp_consts.svh"
`default_nettype none

module sfrp_fifo_read_port (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire sfrp_pkg::sfrp_word_t write_data,
  input  wire logic                 write_enable_n,
  input  wire logic                 read_enable_a_n,
  input  wire logic                 read_enable_b_n,
  input  wire logic                 output_enable_n,
  output sfrp_pkg::sfrp_word_t      read_data,
  output logic                      read_data_oe_n,
  output logic                      empty_flag_n,
  output logic                      almost_empty_flag_n,
  output logic                      almost_full_flag_n,
  output logic                      full_flag_n,
  output logic                      irq,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  // ***************************************************************
  // State
  // ***************************************************************

  typedef struct packed {
    sfrp_pkg::sfrp_level_t  level;
    sfrp_pkg::sfrp_ptr_t    wr_ptr;
    sfrp_pkg::sfrp_ptr_t    rd_ptr;
    logic                   oe_n;
    sfrp_pkg::sfrp_offset_t ae_offset;
    sfrp_pkg::sfrp_offset_t af_offset;
    sfrp_pkg::sfrp_irq_t    irq_status;
    sfrp_pkg::sfrp_irq_t    irq_mask;
    logic                   irq;
    logic [7:0]             awaddr;
    logic                   aw_held;
    logic                   awready;
    logic [31:0]            wdata;
    logic                   wstrb0;
    logic                   w_held;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
  } sfrp_top_st_t;

  sfrp_top_st_t        q;
  sfrp_top_st_t        d;
  logic                do_read;
  logic                do_write;
  logic                read_req;
  logic                write_req;
  sfrp_pkg::sfrp_irq_t events;
  sfrp_pkg::sfrp_irq_t irq_clear;
  logic                ev_empty;
  logic                ev_aempty;
  logic                ev_afull;
  logic                ev_full;
  logic                aw_take;
  logic                w_take;
  logic                ar_take;
  logic [3:0]          flags_n;

  // ***************************************************************
  // Storage and flags
  // ***************************************************************

  sfrp_ram u_ram (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .wr_en   (do_write),
    .wr_addr (q.wr_ptr),
    .wr_data (write_data),
    .rd_en   (do_read),
    .rd_addr (q.rd_ptr),
    .rd_data (read_data)
  );

  sfrp_level_flag #(.AT_OR_ABOVE(1'b0)) u_empty (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .level    (d.level),
    .offset   (8'h00),
    .flag_n   (empty_flag_n),
    .asserted (ev_empty)
  );

  sfrp_level_flag #(.AT_OR_ABOVE(1'b0)) u_almost_empty (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .level    (d.level),
    .offset   (q.ae_offset),
    .flag_n   (almost_empty_flag_n),
    .asserted (ev_aempty)
  );

  sfrp_level_flag #(.AT_OR_ABOVE(1'b1)) u_almost_full (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .level    (d.level),
    .offset   (q.af_offset),
    .flag_n   (almost_full_flag_n),
    .asserted (ev_afull)
  );

  sfrp_level_flag #(.AT_OR_ABOVE(1'b1)) u_full (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .level    (d.level),
    .offset   (8'h00),
    .flag_n   (full_flag_n),
    .asserted (ev_full)
  );

  // ***************************************************************
  // Data path control
  // ***************************************************************

  // The flags are registered from the next level, so each one shows
  // the level that the buffer holds in the current cycle.
  always_comb begin
    read_req  = ~read_enable_a_n & ~read_enable_b_n;
    write_req = ~write_enable_n;
    do_read   = read_req & empty_flag_n;
    do_write  = write_req & full_flag_n;
    flags_n   = {full_flag_n, almost_full_flag_n,
                 almost_empty_flag_n, empty_flag_n};
    events                      = '0;
    events[`SFRP_IRQ_EMPTY]     = ev_empty;
    events[`SFRP_IRQ_AEMPTY]    = ev_aempty;
    events[`SFRP_IRQ_AFULL]     = ev_afull;
    events[`SFRP_IRQ_FULL]      = ev_full;
    events[`SFRP_IRQ_OVERFLOW]  = write_req & ~full_flag_n;
    events[`SFRP_IRQ_UNDERFLOW] = read_req & ~empty_flag_n;
    aw_take = s_axi_awvalid & q.awready;
    w_take  = s_axi_wvalid & q.wready;
    ar_take = s_axi_arvalid & q.arready;
  end

  // ***************************************************************
  // Next state
  // ***************************************************************

  always_comb begin
    d         = q;
    irq_clear = '0;

    if (do_write) begin
      d.wr_ptr = q.wr_ptr + `SFRP_PTR_W'(1);
    end
    if (do_read) begin
      d.rd_ptr = q.rd_ptr + `SFRP_PTR_W'(1);
    end
    if (do_write && !do_read) begin
      d.level = q.level + `SFRP_LEVEL_W'(1);
    end else if (do_read && !do_write) begin
      d.level = q.level - `SFRP_LEVEL_W'(1);
    end

    d.oe_n = output_enable_n;

    // Write address and data are taken in either order.
    if (aw_take) begin
      d.awaddr  = s_axi_awaddr;
      d.aw_held = 1'b1;
    end
    if (w_take) begin
      d.wdata  = s_axi_wdata;
      d.wstrb0 = s_axi_wstrb[0];
      d.w_held = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `SFRP_RESP_OKAY;
      if (q.awaddr == `SFRP_REG_AE_OFFSET) begin
        if (q.wstrb0) begin
          d.ae_offset = q.wdata[7:0];
        end
      end else if (q.awaddr == `SFRP_REG_AF_OFFSET) begin
        if (q.wstrb0) begin
          d.af_offset = q.wdata[7:0];
        end
      end else if (q.awaddr == `SFRP_REG_STATUS) begin
        d.bresp = `SFRP_RESP_OKAY;
      end else if (q.awaddr == `SFRP_REG_IRQ_STATUS) begin
        if (q.wstrb0) begin
          irq_clear = q.wdata[`SFRP_IRQ_W-1:0];
        end
      end else if (q.awaddr == `SFRP_REG_IRQ_MASK) begin
        if (q.wstrb0) begin
          d.irq_mask = q.wdata[`SFRP_IRQ_W-1:0];
        end
      end else begin
        d.bresp = `SFRP_RESP_SLVERR;
      end
    end
    d.awready = ~d.aw_held;
    d.wready  = ~d.w_held;

    // Reads answer one cycle after the address is taken.
    if (q.rvalid && s_axi_rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
    if (ar_take) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = `SFRP_RESP_OKAY;
      d.rdata   = '0;
      if (s_axi_araddr == `SFRP_REG_AE_OFFSET) begin
        d.rdata[7:0] = q.ae_offset;
      end else if (s_axi_araddr == `SFRP_REG_AF_OFFSET) begin
        d.rdata[7:0] = q.af_offset;
      end else if (s_axi_araddr == `SFRP_REG_STATUS) begin
        d.rdata[`SFRP_LEVEL_W-1:0] = q.level;
        d.rdata[`SFRP_STAT_FLAGS_LSB +: 4] = flags_n;
      end else if (s_axi_araddr == `SFRP_REG_IRQ_STATUS) begin
        d.rdata[`SFRP_IRQ_W-1:0] = q.irq_status;
      end else if (s_axi_araddr == `SFRP_REG_IRQ_MASK) begin
        d.rdata[`SFRP_IRQ_W-1:0] = q.irq_mask;
      end else begin
        d.rresp = `SFRP_RESP_SLVERR;
      end
    end

    // A new event wins over a clear in the same cycle.
    d.irq_status = (q.irq_status & ~irq_clear) | events;
    d.irq        = |(d.irq_status & d.irq_mask);
  end

  // ***************************************************************
  // Registers
  // ***************************************************************

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q            <= '0;
      q.oe_n       <= 1'b1;
      q.ae_offset  <= `SFRP_AE_OFFSET_RST;
      q.af_offset  <= `SFRP_AF_OFFSET_RST;
      q.irq_mask   <= `SFRP_IRQ_MASK_RST;
      q.awready    <= 1'b1;
      q.wready     <= 1'b1;
      q.arready    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************

  assign read_data_oe_n = q.oe_n;
  assign irq            = q.irq;
  assign s_axi_awready  = q.awready;
  assign s_axi_wready   = q.wready;
  assign s_axi_bvalid   = q.bvalid;
  assign s_axi_bresp    = q.bresp;
  assign s_axi_arready  = q.arready;
  assign s_axi_rvalid   = q.rvalid;
  assign s_axi_rresp    = q.rresp;
  assign s_axi_rdata    = q.rdata;

endmodule : sfrp_fifo_read_port

`default_nettype wire

// file: sim/sfrp_fifo_read_port_monitor.sv
/*
  Concurrent checks on the ports of the buffer read port.
  Assumes a single clock and is attached by the bind at the foot.
*/
`default_nettype none

module sfrp_fifo_read_port_monitor (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire logic                 write_enable_n,
  input wire logic                 read_enable_a_n,
  input wire logic                 read_enable_b_n,
  input wire logic                 output_enable_n,
  input wire sfrp_pkg::sfrp_word_t read_data,
  input wire logic                 read_data_oe_n,
  input wire logic                 empty_flag_n,
  input wire logic                 almost_empty_flag_n,
  input wire logic                 almost_full_flag_n,
  input wire logic                 full_flag_n
);
  // **********************************
  // Fill level mirror and properties.
  // **********************************
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic       wr_ok;
  logic       rd_ok;

  assign wr_ok = !write_enable_n && full_flag_n;
  assign rd_ok = !read_enable_a_n && !read_enable_b_n && empty_flag_n;

  always_comb cnt_d = cnt_q + 9'(wr_ok) - 9'(rd_ok);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) cnt_q <= 9'h000;
    else cnt_q <= cnt_d;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_rd_req;
    !read_enable_a_n && !read_enable_b_n;
  endsequence
  sequence s_blocked;
    s_rd_req ##0 !empty_flag_n;
  endsequence

  property p_no_rd_empty;
    s_blocked |=> $stable(read_data);
  endproperty
  property p_hold;
    (read_enable_a_n || read_enable_b_n) |=> $stable(read_data);
  endproperty
  property p_empty;
    empty_flag_n == (cnt_q != 9'h000);
  endproperty
  property p_full;
    full_flag_n == (cnt_q != 9'h100);
  endproperty
  property p_oe;
    $past(reset_n) |-> read_data_oe_n == $past(output_enable_n);
  endproperty
  property p_rst;
    $rose(reset_n) |-> !empty_flag_n && !almost_empty_flag_n &&
      full_flag_n && almost_full_flag_n;
  endproperty
  property p_ae;
    !empty_flag_n |-> !almost_empty_flag_n;
  endproperty
  property p_af;
    !full_flag_n |-> !almost_full_flag_n;
  endproperty

  a_no_rd_empty: assert property (p_no_rd_empty)
    else $error("output word moved on a blocked read");
  a_hold: assert property (p_hold)
    else $error("output word moved without a read");
  a_empty: assert property (p_empty)
    else $error("empty flag disagrees with level");
  a_full: assert property (p_full)
    else $error("full flag disagrees with level");
  a_oe: assert property (p_oe)
    else $error("drive enable does not follow request");
  a_rst: assert property (p_rst)
    else $error("flags wrong after reset");
  a_ae: assert property (p_ae)
    else $error("almost-empty high while empty");
  a_af: assert property (p_af)
    else $error("almost-full high while full");
endmodule : sfrp_fifo_read_port_monitor

bind sfrp_fifo_read_port sfrp_fifo_read_port_monitor u_mon (
  .sys_clk, .reset_n, .write_enable_n, .read_enable_a_n, .read_enable_b_n,
  .output_enable_n, .read_data, .read_data_oe_n, .empty_flag_n,
  .almost_empty_flag_n, .almost_full_flag_n, .full_flag_n
);

`default_nettype wire

// file: sim/sfrp_writer_model.sv
/*
  Upstream writer: offers a word with a random write enable.
  Assumes rate is a percentage from 0 to 100.
*/
`default_nettype none

module sfrp_writer_model (
  input  wire logic            sys_clk,
  input  wire logic            reset_n,
  input  wire logic [6:0]      rate,
  output sfrp_pkg::sfrp_word_t write_data,
  output logic                 write_enable_n
);
  // It does not watch the full flag, so refused writes do occur.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_data     <= 9'h000;
      write_enable_n <= 1'b1;
    end else begin
      write_enable_n <= ($urandom_range(99, 0) >= rate);
      write_data     <= 9'($urandom);
    end
  end
endmodule : sfrp_writer_model

`default_nettype wire

// file: sim/sfrp_fifo_read_port_tb.sv
/*
  Self-checking bench of the buffer read port.
  Assumes the design, package, checker and writer model compile first.
*/
`default_nettype none

module sfrp_fifo_read_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [6:0] rate = 7'h00;
  sfrp_pkg::sfrp_word_t write_data, read_data, last_w;
  logic write_enable_n, read_data_oe_n, irq, oe_q;
  logic read_enable_a_n = 1'b1;
  logic read_enable_b_n = 1'b1;
  logic output_enable_n = 1'b1;
  logic empty_flag_n, almost_empty_flag_n, almost_full_flag_n, full_flag_n;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  sfrp_pkg::sfrp_word_t q[$];
  int cnt, ae_off, af_off, err_total, n_tests;

  always #10 sys_clk = ~sys_clk;

  sfrp_fifo_read_port u_sfrp_fifo_read_port (
    .sys_clk, .reset_n, .write_data, .write_enable_n, .read_enable_a_n,
    .read_enable_b_n, .output_enable_n, .read_data, .read_data_oe_n,
    .empty_flag_n, .almost_empty_flag_n, .almost_full_flag_n, .full_flag_n,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  sfrp_writer_model u_sfrp_writer_model (
    .sys_clk, .reset_n, .rate, .write_data, .write_enable_n
  );

  // ************************
  // Expectations and checks.
  // ************************
  function automatic logic exp_ae(input int c);
    return !(c <= ae_off);
  endfunction : exp_ae

  function automatic logic exp_af(input int c);
    return !(c >= 9'h100 - af_off);
  endfunction : exp_af

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    chk_val(32'(got), 32'(exp));
  endtask : chk_flag

  always @(posedge sys_clk) begin
    if (reset_n) begin
      chk_val(32'(read_data), 32'(last_w));
      chk_flag(empty_flag_n, cnt != 0);
      chk_flag(full_flag_n, cnt != 9'h100);
      chk_flag(almost_empty_flag_n, exp_ae(cnt));
      chk_flag(almost_full_flag_n, exp_af(cnt));
      chk_flag(read_data_oe_n, oe_q);
      if (!write_enable_n && full_flag_n) q.push_back(write_data);
      if (!read_enable_a_n && !read_enable_b_n && empty_flag_n) begin
        last_w = q.pop_front();
      end
      cnt = q.size();
      oe_q = output_enable_n;
    end else begin
      q.delete();
      last_w = 9'h000;
      cnt = 0;
      oe_q = 1'b1;
    end
  end

  // ****************************
  // Register bus master tasks.
  // ****************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er = 2'h0);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk_val(32'(s_axi_bresp), 32'(er));
  endtask : axi_wr

  task automatic axi_chk(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk_val(32'(s_axi_rresp), 32'(er));
    if (er == 2'h0) chk_val(s_axi_rdata, ed);
  endtask : axi_chk

  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // ***********
  // Sequence.
  // ***********
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    final_report();
  end

  initial begin
    void'($urandom(80012));
    ae_off = 7;
    af_off = 7;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    axi_chk(8'h00, 32'h7, 2'h0);
    axi_chk(8'h04, 32'h7, 2'h0);
    axi_chk(8'h40, 32'h0, 2'h2);
    axi_wr(8'h10, 32'h10);
    rate <= 7'h64;
    while (full_flag_n !== 1'b0) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    rate <= 7'h00;
    repeat (4) @(posedge sys_clk);
    chk_flag(irq, 1'b1);
    axi_chk(8'h08, 32'h0003_0100, 2'h0);
    axi_wr(8'h10, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk_flag(irq, 1'b0);
    axi_wr(8'h10, 32'h10);
    repeat (3) @(posedge sys_clk);
    chk_flag(irq, 1'b1);
    axi_wr(8'h0c, 32'h3f);
    repeat (3) @(posedge sys_clk);
    chk_flag(irq, 1'b0);
    read_enable_a_n <= 1'b0;
    read_enable_b_n <= 1'b0;
    while (empty_flag_n !== 1'b0) @(posedge sys_clk);
    repeat (6) @(posedge sys_clk);
    read_enable_a_n <= 1'b1;
    read_enable_b_n <= 1'b1;
    ae_off = $urandom_range(40, 1);
    af_off = $urandom_range(40, 1);
    axi_wr(8'h00, 32'(ae_off));
    axi_wr(8'h04, 32'(af_off));
    axi_chk(8'h00, 32'(ae_off), 2'h0);
    for (int p = 0; p < 8; p++) begin
      rate <= p[0] ? 7'h0a : 7'h50;
      repeat (600) begin
        @(posedge sys_clk);
        read_enable_a_n <= 1'($urandom);
        read_enable_b_n <= p[0] ? 1'b0 : 1'($urandom);
        output_enable_n <= 1'($urandom);
      end
    end
    // A reset in mid-run must restore flags, pointers and default offsets.
    @(posedge sys_clk);
    read_enable_a_n <= 1'b1;
    read_enable_b_n <= 1'b1;
    reset_n <= 1'b0;
    @(posedge sys_clk);
    ae_off = 7;
    af_off = 7;
    @(posedge sys_clk);
    reset_n <= 1'b1;
    axi_chk(8'h00, 32'h7, 2'h0);
    axi_chk(8'h04, 32'h7, 2'h0);
    axi_wr(8'h40, 32'h5, 2'h2);
    rate <= 7'h64;
    repeat (20) @(posedge sys_clk);
    read_enable_a_n <= 1'b0;
    read_enable_b_n <= 1'b0;
    repeat (40) @(posedge sys_clk);
    final_report();
  end
endmodule : sfrp_fifo_read_port_tb

`default_nettype wire
